/* src/ads_pkg.sv */
// Shared constants, types and state layout of the conversion sequencer
`default_nettype none
package ads_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_MODE0 = 8'h00;
  localparam logic [7:0] OFS_MODE1 = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_RESULT0 = 8'h10;
  localparam logic [7:0] OFS_RESULT_END = 8'h30;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // ==========================================================
  // Field positions
  localparam int M0_ENABLE = 7;
  localparam int M0_STATUS = 6;
  localparam int M0_BUFCNT = 5;
  localparam int M0_SCANSEL = 4;
  localparam int M0_GROUP = 3;
  localparam int M1_EDGE_LSB = 6;
  localparam int M1_TRG_LSB = 4;
  localparam logic [1:0] TRG_SOFT = 2'b00;
  localparam logic [1:0] TRG_TIMER = 2'b01;
  localparam logic [1:0] TRG_EXT = 2'b10;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_W = 2;
  // ==========================================================
  // Result layout and timing
  localparam int RES_W = 10;
  localparam int RES_PAD = 6;
  localparam logic [9:0] SAR_FIRST = 10'h200;
  localparam logic [3:0] SAR_MSB = 4'h9;
  localparam logic [2:0] FOUR_LAST = 3'h3;
  localparam int CNT_W = 12;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 14400;
  localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int BIT_CYC_DEF = CONV_CYC / RES_W;
  // ==========================================================
  // Sequencer states, Gray along idle-wait-convert-store
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b11,
    ST_STORE = 2'b10
  } ads_state_e;
  typedef logic [7:0][RES_W-1:0] ads_result_t;
  typedef struct packed {
    logic [7:0] mode0;
    logic [7:0] mode1;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic irq;
    ads_result_t result;
    ads_state_e state;
    logic [RES_W-1:0] approximation_register;
    logic [3:0] bitIdx;
    logic [CNT_W-1:0] bitCnt;
    logic [2:0] seqCnt;
    logic [2:0] resIdx;
    logic [3:0] anaChannel;
    logic wbAck;
    logic [31:0] wbDatO;
    logic [1:0] cmpSync;
    logic [1:0] trgSync;
    logic trgPrev;
  } ads_regs_s;
endpackage : ads_pkg
`default_nettype wire

/* src/ads_conversion_sequencer.sv */
// Conversion sequencer of a 10-bit successive-approximation converter
//
// Decided for this implementation: the Wishbone register port and the address map.
`default_nettype none
module ads_conversion_sequencer
  import ads_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // Analog front end
  input wire logic cmpHigh,
  output logic [3:0] anaChannel,
  output logic [15:0] approxTap,
  output logic convBusy,
  // Trigger sources
  input wire logic timerMatch,
  input wire logic extTrigger,
  // Interrupt
  output logic conversionDoneIrq
);

  // ==========================================================
  // Elaboration check
  // Synchroniser latency needs at least three cycles per bit
  if (BIT_CYCLES < 3 || BIT_CYCLES > (1 << CNT_W)) begin : gBadCycles
    $error("BIT_CYCLES out of range");
  end

  // Limitation: conversion-time bits are stored only; BIT_CYCLES fixes timing
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);

  // ==========================================================
  // Channel and result routing for one sequence step
  // Returns {channel, result index}
  function automatic logic [6:0] routeStep(input logic [7:0] m, input logic [2:0] s);
    logic [3:0] ch;
    logic [2:0] idx;
    ch = {m[M0_GROUP], m[2:0]};
    idx = m[2:0];
    if (!m[M0_SCANSEL]) begin
      ch = {m[M0_GROUP], s};
      idx = s;
    end else if (m[M0_BUFCNT]) begin
      // half of the bank by channel bit 2
      idx = {m[2], s[1:0]};
    end
    return {ch, idx};
  endfunction : routeStep

  ads_regs_s r;
  ads_regs_s next_r;
  logic wbHit;
  logic wbDone;
  logic modeWr;
  logic isBusy;
  logic rise;
  logic fall;
  logic trigger;
  logic lastStep;
  logic doStart;
  logic [2:0] startSeq;
  logic [6:0] route;
  logic [1:0] trgSrc;
  logic [1:0] edgeSel;
  logic [2:0] resSel;
  logic [7:0] resOfs;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_r = r;
    doStart = 1'b0;
    startSeq = 3'h0;
    lastStep = 1'b0;
    route = 7'h00;
    wbHit = wbCyc & wbStb;
    // Write and read-clear act on the edge that sees ack high
    wbDone = wbHit & r.wbAck;
    isBusy = (r.state == ST_CONV) || (r.state == ST_STORE);
    trgSrc = r.mode1[M1_TRG_LSB +: 2];
    edgeSel = r.mode1[M1_EDGE_LSB +: 2];
    resOfs = wbAdr - OFS_RESULT0;
    resSel = resOfs[4:2];
    modeWr = wbDone & wbWe & wbSel[0] & ((wbAdr == OFS_MODE0) || (wbAdr == OFS_MODE1));

    // Pin synchronisers; edge logic reads only the second stage
    // A false rise after reset is harmless: reset mode is software trigger
    next_r.cmpSync = {r.cmpSync[0], cmpHigh};
    next_r.trgSync = {r.trgSync[0], extTrigger};
    next_r.trgPrev = r.trgSync[1];
    rise = r.trgSync[1] & ~r.trgPrev;
    fall = ~r.trgSync[1] & r.trgPrev;

    // Trigger selection
    // source field decode; code 11 never fires
    // compare match of the wide timer
    // edge field gates falling and rising
    case (trgSrc)
      TRG_TIMER: trigger = timerMatch;
      TRG_EXT: trigger = (edgeSel[0] & fall) | (edgeSel[1] & rise);
      default: trigger = 1'b0;
    endcase

    // Sequencer
    case (r.state)
      ST_IDLE: begin
        if (r.mode0[M0_ENABLE]) begin
          if (trgSrc == TRG_SOFT) begin
            doStart = 1'b1;
          end else begin
            next_r.state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // Triggers outside this state are dropped, never queued
        if (!r.mode0[M0_ENABLE]) begin
          next_r.state = ST_IDLE;
        end else if (trigger) begin
          doStart = 1'b1;
        end
      end
      ST_CONV: begin
        next_r.bitCnt = r.bitCnt + 1'b1;
        if (r.bitCnt == BIT_LAST) begin
          next_r.bitCnt = '0;
          // keep trial bit only if input is at or above tap
          if (!r.cmpSync[1]) begin
            next_r.approximation_register[r.bitIdx] = 1'b0;
          end
          if (r.bitIdx == 4'h0) begin
            next_r.state = ST_STORE;
          end else begin
            next_r.bitIdx = r.bitIdx - 1'b1;
            next_r.approximation_register[r.bitIdx - 1'b1] = 1'b1;
          end
        end
      end
      ST_STORE: begin
        // store only once every bit is settled
        next_r.result[r.resIdx] = r.approximation_register;
        // mode decode picks the end of the sequence
        if (!r.mode0[M0_SCANSEL]) begin
          // scan ends at the selected channel
          lastStep = r.seqCnt == r.mode0[2:0];
        end else if (r.mode0[M0_BUFCNT]) begin
          lastStep = r.seqCnt == FOUR_LAST;
        end else begin
          lastStep = 1'b1;
        end
        if (lastStep) begin
          next_r.irqStat[IRQ_DONE] = 1'b1;
          if (trgSrc == TRG_SOFT) begin
            // cleared enable lets a new write restart
            next_r.mode0[M0_ENABLE] = 1'b0;
            next_r.state = ST_IDLE;
          end else begin
            // back to waiting for the next trigger
            next_r.state = ST_WAIT;
          end
        end else begin
          // Next step follows at once, with no idle gap
          doStart = 1'b1;
          startSeq = r.seqCnt + 1'b1;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase

    // Launch one conversion step
    if (doStart) begin
      route = routeStep(r.mode0, startSeq);
      next_r.anaChannel = route[6:3];
      next_r.resIdx = route[2:0];
      next_r.seqCnt = startSeq;
      next_r.approximation_register = SAR_FIRST;
      next_r.bitIdx = SAR_MSB;
      next_r.bitCnt = '0;
      next_r.state = ST_CONV;
    end

    // Register reads; status clear precedes any hardware set
    next_r.wbAck = wbHit & ~r.wbAck;
    next_r.wbDatO = '0;
    if (wbHit && !r.wbAck && !wbWe) begin
      if (wbAdr == OFS_MODE0) begin
        // status bit shows the busy state
        next_r.wbDatO[7:0] = {r.mode0[7], isBusy, r.mode0[5:0]};
      end else if (wbAdr == OFS_MODE1) begin
        next_r.wbDatO[7:0] = r.mode1;
      end else if (wbAdr == OFS_IRQ_STAT) begin
        next_r.wbDatO[IRQ_W-1:0] = r.irqStat;
      end else if (wbAdr == OFS_IRQ_MASK) begin
        next_r.wbDatO[IRQ_W-1:0] = r.irqMask;
      end else if (wbAdr >= OFS_RESULT0 && wbAdr < OFS_RESULT_END && wbAdr[1:0] == 2'b00) begin
        // result left-justified, low six bits zero
        next_r.wbDatO[15:0] = {r.result[resSel], {RES_PAD{1'b0}}};
      end
    end
    if (wbDone && !wbWe && wbAdr == OFS_IRQ_STAT) begin
      // Clear only what the read returned; a set landing after the data
      // was latched would otherwise be lost unseen
      next_r.irqStat = r.irqStat & ~r.wbDatO[IRQ_W-1:0];
      if (r.state == ST_STORE && lastStep) begin
        next_r.irqStat[IRQ_DONE] = 1'b1;
      end
    end

    // Register writes; mode writes also abort the sequence
    // Writes land on the edge that samples ack high
    if (wbDone && wbWe && wbSel[0]) begin
      if (wbAdr == OFS_MODE0) begin
        next_r.mode0 = {wbDatI[7], 1'b0, wbDatI[5:0]};
      end else if (wbAdr == OFS_MODE1) begin
        next_r.mode1 = wbDatI[7:0];
      end else if (wbAdr == OFS_IRQ_MASK) begin
        next_r.irqMask = wbDatI[IRQ_W-1:0];
      end
    end
    if (modeWr) begin
      // drop the running conversion and its result
      next_r.result = r.result;
      // An abandoned last step neither flags done nor drops the enable
      next_r.irqStat[IRQ_DONE] = r.irqStat[IRQ_DONE];
      if (wbAdr == OFS_MODE1) begin
        next_r.mode0 = r.mode0;
      end
      next_r.state = ST_IDLE;
      if (isBusy) begin
        next_r.irqStat[IRQ_ABORT] = 1'b1;
      end
    end

    // Level interrupt registered from the next status
    next_r.irq = |(next_r.irqStat & next_r.irqMask);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      // Mode registers take their reset value; everything else clears
      r <= '0;
      r.mode0 <= MODE_RESET;
      r.mode1 <= MODE_RESET;
      r.state <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  // Read data and ack stand for one cycle only
  assign wbDatO = r.wbDatO;
  assign wbAck = r.wbAck;
  assign anaChannel = r.anaChannel;
  // approximation value left-justified on the tap bus
  assign approxTap = {r.approximation_register, {RES_PAD{1'b0}}};
  // Gray coding puts both busy states in the upper state bit
  assign convBusy = r.state[1];
  assign conversionDoneIrq = r.irq;

endmodule : ads_conversion_sequencer
`default_nettype wire

/* tb/ads_seq_properties.sv */
// Port-level property checker of the conversion sequencer
`default_nettype none
module ads_seq_properties
  import ads_pkg::*;
#(
  parameter int BIT_CYCLES = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register bus
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  // Converter side
  input wire logic [15:0] approxTap,
  input wire logic convBusy,
  input wire logic timerMatch,
  input wire logic conversionDoneIrq
);
  localparam int CONV_LEN = 10 * BIT_CYCLES + 1;
  logic [1:0] trig;
  logic en;
  logic [11:0] busyCnt;
  logic modeWr;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // Mode register write at its acknowledge
  assign modeWr = wbAck && wbWe && wbSel[0] && wbAdr[7:3] == 5'h00;
  // Shadow of trigger source, enable and busy run length
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trig <= TRG_SOFT;
      en <= 1'b0;
      busyCnt <= '0;
    end else begin
      trig <= (modeWr && wbAdr[2]) ? wbDatI[5:4] : trig;
      en <= (modeWr && !wbAdr[2]) ? wbDatI[7] : en;
      busyCnt <= convBusy ? busyCnt + 12'h001 : '0;
    end
  end
  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack held over one cycle");
  tap_start_a: assert property ($rose(convBusy) |-> approxTap == 16'h8000)
    else $error("conversion did not begin at top bit");
  conv_len_a: assert property ($rose(conversionDoneIrq) && $past(convBusy) &&
    !$past(wbAck) |-> busyCnt % CONV_LEN == 0)
    else $error("done raised before whole conversions");
  sw_start_a: assert property (modeWr && !wbAdr[2] && wbDatI[7] &&
    trig == TRG_SOFT && !convBusy |=> ##1 convBusy)
    else $error("software enable did not start");
  hw_start_a: assert property (trig == TRG_TIMER && $rose(convBusy) |->
    $past(timerMatch))
    else $error("start without trigger");
  timer_start_a: assert property (trig == TRG_TIMER && en && !convBusy &&
    timerMatch && !$past(modeWr) |=> convBusy)
    else $error("compare match ignored");
  mode_abort_a: assert property (modeWr && convBusy && !(!wbAdr[2] && wbDatI[7])
    |=> !convBusy)
    else $error("mode write did not abandon conversion");
  result_pad_a: assert property (wbAck && !wbWe && wbAdr >= OFS_RESULT0 &&
    wbAdr < OFS_RESULT_END |-> wbDatO[5:0] == 6'h00)
    else $error("result low bits not zero");
  cover property ($rose(conversionDoneIrq));
  cover property (modeWr && convBusy);
  cover property (timerMatch && !convBusy);
  cover property (trig == TRG_EXT && $rose(convBusy));
endmodule : ads_seq_properties
bind ads_conversion_sequencer ads_seq_properties #(.BIT_CYCLES(BIT_CYCLES)) props_inst (.*);
`default_nettype wire

/* tb/ads_analog_model.sv */
// Far side model: analog inputs, timer compare channel, trigger pin
`default_nettype none
module ads_analog_model (
  // Clock
  input wire logic clock,
  // Converter side
  input wire logic [3:0] anaChannel,
  input wire logic [15:0] approxTap,
  output logic cmpHigh,
  // Bench controls
  input wire logic [15:0][9:0] levels,
  input wire logic fireTimer,
  input wire logic pinLevel,
  // Trigger sources
  output logic timerMatch = 1'b0,
  output logic extTrigger
);
  assign cmpHigh = levels[anaChannel] >= approxTap[15:6];
  always @(posedge clock) begin
    timerMatch <= fireTimer;
  end
  // pin edges come from the bench
  assign extTrigger = pinLevel;
endmodule : ads_analog_model
`default_nettype wire

/* tb/adc_conversion_sequencer_test.sv */
// Self-checking bench of the conversion sequencer
`default_nettype none
module adc_conversion_sequencer_test
  import ads_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, nrst = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [3:0] wbSel = '0;
  logic [7:0] wbAdr = '0;
  logic [31:0] wbDatI = '0, wbDatO;
  logic wbAck, cmpHigh, convBusy, timerMatch, extTrigger, conversionDoneIrq, fired;
  logic fireTimer = 1'b0, pinLevel = 1'b0;
  logic [3:0] anaChannel, ch;
  logic [15:0] approxTap;
  logic [7:0] m0;
  logic [15:0][9:0] levels;
  logic [31:0] rnd = 32'hdba6_369c;
  logic [32:0] notes[$];
  logic [32:0] note;
  logic [9:0] shadow[8] = '{default: '0};
  logic [7:0] modes[4] = '{8'h90, 8'hB0, 8'hB0, 8'h80};
  int miscompares = 0;
  int num_checks = 0;
  ads_conversion_sequencer #(.BIT_CYCLES(4)) ads_conversion_sequencer_inst (.clock, .nrst,
    .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO, .wbAck, .cmpHigh, .anaChannel,
    .approxTap, .convBusy, .timerMatch, .extTrigger, .conversionDoneIrq);
  ads_analog_model ads_analog_model_inst (.clock, .anaChannel, .approxTap, .cmpHigh,
    .levels, .fireTimer, .pinLevel, .timerMatch, .extTrigger);
  // 20 MHz clock
  always #25 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  task automatic hang();
    miscompares++;
    end_of_test();
  endtask : hang
  // One classic cycle; a read notes its expected data
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    notes.push_back({!we, dat});
    {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatI} <= {2'b11, we, 4'h1, adr, dat};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (wbAck !== 1'b1) hang();
    {wbCyc, wbStb} <= 2'b00;
    @(posedge clock);
  endtask : wb
  task automatic wait_irq(input int lim);
    fired = 1'b0;
    for (int i = 0; i < lim && !fired; i++) begin
      @(posedge clock);
      fired = conversionDoneIrq === 1'b1;
    end
  endtask : wait_irq
  // Acknowledged reads against the oldest note
  always @(posedge clock) begin
    if (wbAck === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note[32]) check("read data", wbDatO, note[31:0]);
    end
  end
  initial begin
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      levels[i] = rnd[9:0];
    end
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    wb(0, OFS_MODE1, '0);
    wb(0, OFS_RESULT0, '0);
    wb(0, 8'h40, '0);
    wb(1, OFS_IRQ_MASK, 32'h3);
    // Software runs: one-buffer, four-buffer twice, scan
    for (int m = 0; m < 4; m++) begin
      rnd = lfsr(rnd);
      ch = rnd[3:0];
      m0 = modes[m] | {4'h0, ch};
      wb(1, OFS_MODE0, {24'h0, m0});
      wait_irq(800);
      if (!fired) hang();
      for (int k = 0; k < 8; k++) begin
        if (m0[5:4] == 2'b01 && k == ch[2:0]) shadow[k] = levels[ch];
        if (m0[5:4] == 2'b11 && k[2] == ch[2]) shadow[k] = levels[ch];
        if (!m0[4] && k <= ch[2:0]) shadow[k] = levels[{ch[3], k[2:0]}];
        wb(0, OFS_RESULT0 + 8'(k * 4), {16'h0, shadow[k], 6'h0});
      end
      wb(0, OFS_IRQ_STAT, 32'h1);
      check("irq", 32'(conversionDoneIrq), '0);
      wb(0, OFS_MODE0, {24'h0, m0 & 8'h3F});
      $display("software run %0d done", m);
    end
    // Mode write mid-conversion
    levels[ch] <= ~levels[ch];
    m0 = 8'h90 | {4'h0, ch};
    wb(1, OFS_MODE0, {24'h0, m0});
    wb(0, OFS_MODE0, {24'h0, m0 | 8'h40});
    check("channel", 32'(anaChannel), 32'(ch));
    wb(1, OFS_MODE0, {24'h0, m0 & 8'h7F});
    wb(0, OFS_IRQ_STAT, 32'h2);
    wb(0, OFS_RESULT0 + 8'(ch[2:0] * 4), {16'h0, shadow[ch[2:0]], 6'h0});
    $display("abort done");
    // Timer trigger, done masked then unmasked
    wb(1, OFS_MODE1, 32'h10);
    wb(1, OFS_IRQ_MASK, '0);
    wb(1, OFS_MODE0, {24'h0, m0});
    repeat (50) @(posedge clock);
    check("standby", 32'(convBusy), '0);
    fireTimer <= 1'b1;
    @(posedge clock);
    fireTimer <= 1'b0;
    repeat (60) @(posedge clock);
    check("masked irq", 32'(conversionDoneIrq), '0);
    wb(1, OFS_IRQ_MASK, 32'h3);
    check("irq", 32'(conversionDoneIrq), 32'h1);
    wb(0, OFS_RESULT0 + 8'(ch[2:0] * 4), {16'h0, levels[ch], 6'h0});
    wb(0, OFS_IRQ_STAT, 32'h1);
    wb(0, OFS_MODE0, {24'h0, m0});
    $display("timer done");
    // Every edge setting against rising then falling pin
    for (int e = 0; e < 4; e++) begin
      wb(1, OFS_MODE1, {24'h0, 2'(e), 6'h20});
      for (int p = 1; p >= 0; p--) begin
        pinLevel <= p[0];
        wait_irq(60);
        check("edge start", 32'(fired), 32'(e[p]));
        wb(0, OFS_IRQ_STAT, 32'(fired));
      end
    end
    $display("external done");
    end_of_test();
  end
endmodule : adc_conversion_sequencer_test
`default_nettype wire
